/* File: design/rtc_interrupt_enable_flags.sv */
`timescale 1ns/10ps
`include "rtc_irq_consts.svh"

module rtc_interrupt_enable_flags #(
  parameter int unsigned RELEASE_CYCLES = `RTC_AUTO_RELEASE_US * `RTC_CLK_MHZ
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire rtc_irq_pkg::bus_req_t busReq,
  output logic [7:0] rdData,
  // Event sources
  input wire rtc_irq_pkg::events_t events,
  // Serial chip enable pin
  input wire logic chipEnable,
  // Clock counter control
  output logic counterReset,
  // Open-drain interrupt pin
  output logic irqOut,
  output logic irqOe
);

  localparam int CW = `RTC_RELEASE_CNT_W;
  localparam logic [CW-1:0] RELOAD = CW'(RELEASE_CYCLES - 1);

  rtc_irq_pkg::ctrl_state_t state;
  rtc_irq_pkg::ctrl_state_t next_state;

  logic ceSync;
  logic flagWrite;
  logic ctrlWrite;
  logic updateFlag;
  logic timerFlag;
  logic alarmFlag;
  logic dataLossFlag;
  logic compStopFlag;
  logic updateRise;
  logic timerRise;
  logic alarmRise;
  logic [7:0] flagImage;
  logic [7:0] ctrlImage;

  // ---------------------------------------------------------------
  // Chip enable synchroniser
  // ---------------------------------------------------------------
  pin_sync u_ce_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .pinIn(chipEnable),
    .syncOut(ceSync)
  );

  // ---------------------------------------------------------------
  // Address decode
  // ---------------------------------------------------------------
  assign flagWrite = busReq.wr && (busReq.addr == `RTC_FLAG_ADDR);
  assign ctrlWrite = busReq.wr && (busReq.addr == `RTC_CTRL_ADDR);

  // ---------------------------------------------------------------
  // Event flags
  // ---------------------------------------------------------------
  event_flag_cell #(
    .RESET_VALUE(`RTC_RST_UPDATE)
  ) u_update_flag (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .setEvent(events.update),
    .clearWrite(flagWrite && !busReq.wdata[`RTC_BIT_UPDATE]),
    .flag(updateFlag),
    .rise(updateRise)
  );

  event_flag_cell #(
    .RESET_VALUE(`RTC_RST_TIMER)
  ) u_timer_flag (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .setEvent(events.timer),
    .clearWrite(flagWrite && !busReq.wdata[`RTC_BIT_TIMER]),
    .flag(timerFlag),
    .rise(timerRise)
  );

  event_flag_cell #(
    .RESET_VALUE(`RTC_RST_ALARM)
  ) u_alarm_flag (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .setEvent(events.alarm),
    .clearWrite(flagWrite && !busReq.wdata[`RTC_BIT_ALARM]),
    .flag(alarmFlag),
    .rise(alarmRise)
  );

  // Power-up leaves this flag at one so software knows to reinitialise.
  event_flag_cell #(
    .RESET_VALUE(`RTC_RST_DATA_LOSS)
  ) u_data_loss_flag (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .setEvent(events.dataLoss),
    .clearWrite(flagWrite && !busReq.wdata[`RTC_BIT_DATA_LOSS]),
    .flag(dataLossFlag),
    .rise()
  );

  event_flag_cell #(
    .RESET_VALUE(`RTC_RST_COMP_STOP)
  ) u_comp_stop_flag (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .setEvent(events.compStop),
    .clearWrite(flagWrite && !busReq.wdata[`RTC_BIT_COMP_STOP]),
    .flag(compStopFlag),
    .rise()
  );

  // ---------------------------------------------------------------
  // Register images
  // ---------------------------------------------------------------
  always_comb begin
    flagImage = 8'h00;
    flagImage[`RTC_BIT_UPDATE] = updateFlag;
    flagImage[`RTC_BIT_TIMER] = timerFlag;
    flagImage[`RTC_BIT_ALARM] = alarmFlag;
    flagImage[`RTC_BIT_DATA_LOSS] = dataLossFlag;
    flagImage[`RTC_BIT_COMP_STOP] = compStopFlag;
  end

  always_comb begin
    ctrlImage = 8'h00;
    ctrlImage[`RTC_BIT_UPDATE] = state.updateIrqEnable;
    ctrlImage[`RTC_BIT_TIMER] = state.timerIrqEnable;
    ctrlImage[`RTC_BIT_ALARM] = state.alarmIrqEnable;
    ctrlImage[`RTC_BIT_CNT_RESET] = state.counterReset;
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    next_state = state;

    // Control register writes.
    if (ctrlWrite) begin
      next_state.updateIrqEnable = busReq.wdata[`RTC_BIT_UPDATE];
      next_state.timerIrqEnable = busReq.wdata[`RTC_BIT_TIMER];
      next_state.alarmIrqEnable = busReq.wdata[`RTC_BIT_ALARM];
    end

    // Counter reset is set by software and released once the chip
    // enable pin has gone low; a new write of one wins over release.
    if (ctrlWrite && busReq.wdata[`RTC_BIT_CNT_RESET]) begin
      next_state.counterReset = 1'b1;
    end else if (!ceSync) begin
      next_state.counterReset = 1'b0;
    end

    // Update source: timed release after the fixed interval.
    if (updateRise && state.updateIrqEnable) begin
      next_state.updateActive = 1'b1;
      next_state.updateCount = RELOAD;
    end else if (state.updateActive) begin
      if (state.updateCount == '0) begin
        next_state.updateActive = 1'b0;
      end else begin
        next_state.updateCount = state.updateCount - CW'(1);
      end
    end
    if (!next_state.updateIrqEnable) begin
      next_state.updateActive = 1'b0;
    end

    // Timer source: timed release, cancelled by its enable.
    if (timerRise && state.timerIrqEnable) begin
      next_state.timerActive = 1'b1;
      next_state.timerCount = RELOAD;
    end else if (state.timerActive) begin
      if (state.timerCount == '0) begin
        next_state.timerActive = 1'b0;
      end else begin
        next_state.timerCount = state.timerCount - CW'(1);
      end
    end
    if (!next_state.timerIrqEnable) begin
      next_state.timerActive = 1'b0;
    end

    // Alarm source: held until the alarm flag is cleared.
    if (alarmRise && state.alarmIrqEnable) begin
      next_state.alarmActive = 1'b1;
    end else if (!alarmFlag) begin
      next_state.alarmActive = 1'b0;
    end
    if (!next_state.alarmIrqEnable) begin
      next_state.alarmActive = 1'b0;
    end

    // With all enables at zero the pin never drives.
    next_state.irqDrive = next_state.updateActive | next_state.timerActive
                          | next_state.alarmActive;

    // Read data stand for exactly one cycle after the read strobe.
    next_state.rdData = 8'h00;
    if (busReq.rd) begin
      if (busReq.addr == `RTC_FLAG_ADDR) begin
        next_state.rdData = flagImage;
      end else if (busReq.addr == `RTC_CTRL_ADDR) begin
        next_state.rdData = ctrlImage;
      end
    end
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
      state.updateIrqEnable <= `RTC_RST_ENABLE;
      state.timerIrqEnable <= `RTC_RST_ENABLE;
      state.alarmIrqEnable <= `RTC_RST_ENABLE;
      state.counterReset <= `RTC_RST_CNT_RESET;
    end else begin
      state <= next_state;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign rdData = state.rdData;
  assign counterReset = state.counterReset;
  assign irqOut = 1'b0;
  assign irqOe = state.irqDrive;

endmodule

/* File: design/rtc_irq_consts.svh */
`ifndef RTC_IRQ_CONSTS_SVH
`define RTC_IRQ_CONSTS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define RTC_FLAG_ADDR 8'h0f
`define RTC_CTRL_ADDR 8'h10

// ---------------------------------------------------------------
// Field positions; update, timer and alarm are shared by the flag and control registers
// ---------------------------------------------------------------
`define RTC_BIT_UPDATE 5
`define RTC_BIT_TIMER 4
`define RTC_BIT_ALARM 3
`define RTC_BIT_DATA_LOSS 1
`define RTC_BIT_COMP_STOP 0
`define RTC_BIT_CNT_RESET 0

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RTC_RST_UPDATE 1'b0
`define RTC_RST_TIMER 1'b0
`define RTC_RST_ALARM 1'b0
`define RTC_RST_DATA_LOSS 1'b1
`define RTC_RST_COMP_STOP 1'b1
`define RTC_RST_ENABLE 1'b0
`define RTC_RST_CNT_RESET 1'b0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define RTC_CLK_MHZ 200
`define RTC_AUTO_RELEASE_US 7800
`define RTC_RELEASE_CNT_W 21

`endif

/* File: design/rtc_irq_pkg.sv */
package rtc_irq_pkg;

`include "rtc_irq_consts.svh"

  // Register port request, one cycle per access.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  // Single-cycle event pulses from the clock, timer and monitor logic.
  typedef struct packed {
    logic update;
    logic timer;
    logic alarm;
    logic dataLoss;
    logic compStop;
  } events_t;

  typedef struct packed {
    logic stage1;
    logic stage2;
  } sync_state_t;

  typedef struct packed {
    logic flag;
  } flag_state_t;

  typedef struct packed {
    logic updateIrqEnable;
    logic timerIrqEnable;
    logic alarmIrqEnable;
    logic counterReset;
    logic updateActive;
    logic timerActive;
    logic alarmActive;
    logic [`RTC_RELEASE_CNT_W-1:0] updateCount;
    logic [`RTC_RELEASE_CNT_W-1:0] timerCount;
    logic irqDrive;
    logic [7:0] rdData;
  } ctrl_state_t;

endpackage

/* File: design/pin_sync.sv */
`timescale 1ns/10ps

module pin_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Pin and synchronised level
  input wire logic pinIn,
  output logic syncOut
);

  rtc_irq_pkg::sync_state_t state;
  rtc_irq_pkg::sync_state_t next_state;

  always_comb begin
    next_state.stage1 = pinIn;
    next_state.stage2 = state.stage1;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign syncOut = state.stage2;

endmodule

/* File: design/event_flag_cell.sv */
`timescale 1ns/10ps

module event_flag_cell #(
  parameter logic RESET_VALUE = 1'b0
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Set by hardware, cleared by a zero written from software
  input wire logic setEvent,
  input wire logic clearWrite,
  // Flag and its 0 to 1 transition
  output logic flag,
  output logic rise
);

  rtc_irq_pkg::flag_state_t state;
  rtc_irq_pkg::flag_state_t next_state;

  // A set in the same cycle as a clear wins, so no event is lost.
  always_comb begin
    next_state = state;
    if (setEvent) begin
      next_state.flag = 1'b1;
    end else if (clearWrite) begin
      next_state.flag = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state.flag <= RESET_VALUE;
    end else begin
      state <= next_state;
    end
  end

  assign flag = state.flag;
  assign rise = setEvent & ~state.flag;

endmodule

/* File: verif/rtc_irq_asserts.sv */
`timescale 1ns/10ps
`include "rtc_irq_consts.svh"

module rtc_irq_asserts #(
  parameter int unsigned RELEASE_CYCLES = 16
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  // Register port
  input wire rtc_irq_pkg::bus_req_t busReq,
  input wire logic [7:0] rdData,
  // Events and pins
  input wire rtc_irq_pkg::events_t events,
  input wire logic chipEnable,
  input wire logic counterReset,
  input wire logic irqOut,
  input wire logic irqOe
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  rd_idle_zero_a: assert property (!$past(busReq.rd) |-> rdData == 8'h00)
    else $error("read data not zero outside read cycle");
  flag_reserved_a: assert property ($past(busReq.rd) && $past(busReq.addr) == `RTC_FLAG_ADDR
    |-> rdData[7:6] == 2'b00 && rdData[2] == 1'b0)
    else $error("unused flag bits not zero");
  unmapped_zero_a: assert property ($past(busReq.rd) && $past(busReq.addr) != `RTC_FLAG_ADDR
    && $past(busReq.addr) != `RTC_CTRL_ADDR |-> rdData == 8'h00)
    else $error("unmapped read not zero");
  irq_cause_a: assert property ($rose(irqOe) |->
    $past(events.update || events.timer || events.alarm))
    else $error("interrupt asserted without event");
  enable_off_a: assert property (busReq.wr && busReq.addr == `RTC_CTRL_ADDR
    && busReq.wdata[5:3] == 3'b000 |-> ##[1:2] !irqOe)
    else $error("interrupt not cancelled by enable write");
  cnt_reset_set_a: assert property (busReq.wr && busReq.addr == `RTC_CTRL_ADDR
    && busReq.wdata[0] |=> counterReset)
    else $error("counter reset not set");
  cnt_reset_release_a: assert property (!chipEnable [*4] ##0 !$past(busReq.wr)
    |-> !counterReset)
    else $error("counter reset not released");
  irq_data_low_a: assert property (irqOut == 1'b0)
    else $error("interrupt pin data not low");

  cover property ($rose(irqOe));
  cover property ($fell(counterReset));
  cover property (busReq.rd ##1 rdData != 8'h00);
endmodule

bind rtc_interrupt_enable_flags rtc_irq_asserts #(.RELEASE_CYCLES(RELEASE_CYCLES)) u_chk (
  .ref_clk(ref_clk), .rst_n(rst_n), .busReq(busReq), .rdData(rdData),
  .events(events), .chipEnable(chipEnable), .counterReset(counterReset),
  .irqOut(irqOut), .irqOe(irqOe));

/* File: verif/rtc_host_model.sv */
`timescale 1ns/10ps

module rtc_host_model (
  // Open-drain pin from the device
  input wire logic irqOut,
  input wire logic irqOe,
  // Level seen by the host, pulled up when released
  output logic irqN
);
  assign irqN = irqOe ? irqOut : 1'b1;
endmodule

/* File: verif/rtc_interrupt_enable_flags_tb.sv */
`timescale 1ns/10ps
`include "rtc_irq_consts.svh"

module rtc_interrupt_enable_flags_tb;
  localparam int RC = 16;
  localparam logic [7:0] FA = `RTC_FLAG_ADDR;
  localparam logic [7:0] CA = `RTC_CTRL_ADDR;
  typedef struct packed {
    logic [7:0] en;
    rtc_irq_pkg::events_t ev;
    logic oe;
    logic [7:0] fl;
  } row_t;
  row_t rows [6] = '{'{8'h20, 5'b10000, 1'b1, 8'h20}, '{8'h10, 5'b01000, 1'b1, 8'h10},
    '{8'h08, 5'b00100, 1'b1, 8'h08}, '{8'h08, 5'b10000, 1'b0, 8'h20},
    '{8'h00, 5'b01000, 1'b0, 8'h10}, '{8'h38, 5'b00010, 1'b0, 8'h02}};
  logic ref_clk = 0;
  logic rst_n;
  rtc_irq_pkg::bus_req_t busReq;
  rtc_irq_pkg::events_t events;
  logic chipEnable;
  logic [7:0] rdData;
  logic [7:0] d;
  logic counterReset, irqOut, irqOe, irqN;
  int num_errors = 0;
  int checks = 0;

  always #2.5 ref_clk = ~ref_clk;

  rtc_interrupt_enable_flags #(.RELEASE_CYCLES(RC)) u_dut (.ref_clk(ref_clk), .rst_n(rst_n),
    .busReq(busReq), .rdData(rdData), .events(events), .chipEnable(chipEnable),
    .counterReset(counterReset), .irqOut(irqOut), .irqOe(irqOe));
  rtc_host_model u_host (.irqOut(irqOut), .irqOe(irqOe), .irqN(irqN));

  task finish_test;
    $display("errors=%0d checks=%0d", num_errors, checks);
    if (num_errors == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task chk(input logic [7:0] e, input logic [7:0] a);
    checks++;
    if (a !== e) begin
      num_errors++;
      $display("mismatch t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk) busReq <= '{a, v, 1'b1, 1'b0};
    @(posedge ref_clk) busReq.wr <= 1'b0;
  endtask

  task rd(input logic [7:0] a);
    @(posedge ref_clk) busReq <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge ref_clk) busReq.rd <= 1'b0;
    #1 d = rdData;
  endtask

  task pulse(input rtc_irq_pkg::events_t e);
    @(posedge ref_clk) events <= e;
    @(posedge ref_clk) events <= '0;
    #1;
  endtask

  task pin(input logic e);
    chk({7'h0, e}, {7'h0, irqN});
  endtask

  initial begin
    #20000;
    num_errors++;
    finish_test();
  end

  initial begin
    rst_n = 0;
    busReq = '0;
    events = '0;
    chipEnable = 1;
    repeat (12) @(posedge ref_clk);
    rst_n <= 1;
    rd(FA); chk(8'h03, d);
    wr(CA, 8'h00);
    wr(FA, 8'h00);
    foreach (rows[i]) begin
      wr(CA, 8'h00);
      wr(FA, 8'h00);
      wr(CA, rows[i].en);
      pulse(rows[i].ev);
      pin(~rows[i].oe);
      rd(FA); chk(rows[i].fl, d);
    end
    for (int k = 0; k < 2; k++) begin
      wr(FA, 8'h00);
      wr(CA, 8'h10 << k);
      pulse(5'b01000 << k);
      repeat (RC - 1) @(posedge ref_clk);
      #1 pin(1'b0);
      repeat (2) @(posedge ref_clk);
      #1 pin(1'b1);
      rd(FA); chk(8'h10 << k, d);
    end
    for (int k = 0; k < 2; k++) begin
      wr(FA, 8'h00);
      wr(CA, 8'h10 >> k);
      pulse(5'b01000 >> k);
      pin(1'b0);
      wr(CA, 8'h00);
      @(posedge ref_clk) #1 pin(1'b1);
    end
    wr(FA, 8'h00);
    wr(CA, 8'h18);
    pulse(5'b00100);
    pulse(5'b01000);
    repeat (RC + 2) @(posedge ref_clk);
    #1 pin(1'b0);
    wr(FA, 8'hf7);
    @(posedge ref_clk) #1 pin(1'b1);
    rd(FA); chk(8'h10, d);
    wr(CA, 8'h00);
    wr(FA, 8'h00);
    wr(FA, 8'hff);
    rd(FA); chk(8'h00, d);
    pulse(5'b00011);
    wr(FA, 8'hff);
    rd(FA); chk(8'h03, d);
    wr(FA, 8'hfc);
    rd(FA); chk(8'h00, d);
    wr(CA, 8'h01);
    #1 chk(8'h01, {7'h0, counterReset});
    repeat (5) @(posedge ref_clk);
    chipEnable <= 0;
    repeat (4) @(posedge ref_clk);
    #1 chk(8'h00, {7'h0, counterReset});
    chipEnable <= 1;
    wr(8'h20, 8'hff);
    rd(8'h20); chk(8'h00, d);
    @(posedge ref_clk) rst_n <= 0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1;
    rd(FA); chk(8'h03, d);
    finish_test();
  end
endmodule
